// *** rtl/rfcp_pkg.sv ***
// Purpose: Shared constants and types for the radio-settings command handler.
// Assumes: 50 MHz clock, commands arrive as decoded bytes while configuration mode is selected.
// Notes:   Frequencies are carried in units of 12.5 kHz steps.
package rfcp_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int PROMPT_DELAY_US = 1700;
  localparam int CHAN_DELAY_US = 43000;
  localparam int PROMPT_CYC = (PROMPT_DELAY_US * (CLK_HZ / 1_000_000));
  localparam int CHAN_CYC = (CHAN_DELAY_US * (CLK_HZ / 1_000_000));
  localparam logic [7:0] CMD_CHAN = 8'h43;
  localparam logic [7:0] CMD_POWER = 8'h50;
  localparam logic [7:0] CMD_RSSI = 8'h53;
  localparam logic [7:0] CMD_CONT_TX = 8'h32;
  localparam logic [7:0] PROMPT_CHAR = 8'h3E;
  localparam logic [6:0] CHAN_MIN = 7'h01;
  localparam logic [6:0] CHAN_MAX = 7'h50;
  localparam logic [6:0] CHAN_HIGH_BAND = 7'h3C;
  localparam logic [6:0] CHAN_FACTORY = 7'h31;
  localparam logic [2:0] POWER_MIN = 3'h1;
  localparam logic [2:0] POWER_MAX = 3'h5;
  localparam logic [2:0] POWER_FACTORY = 3'h5;
  // Base frequencies in 12.5 kHz steps: 447.2625 MHz and 424.7000 MHz.
  localparam logic [15:0] BASE_LOW_STEPS = 16'h8BC5;
  localparam logic [15:0] BASE_HIGH_STEPS = 16'h84B8;
  localparam logic [7:0] AIR_RATE_FACTORY = 8'h00;
  typedef enum {RFCP_AMP_IDLE, RFCP_AMP_RX, RFCP_AMP_TX} rfcp_radio_t;
  typedef struct packed {
    logic [6:0] channel;
    logic [2:0] power;
    logic [7:0] air_rate;
  } rfcp_setting_t;
  typedef struct packed {
    logic [15:0] freq_steps;
    logic signed [7:0] power_dbm;
  } rfcp_tune_t;
endpackage

// *** rtl/rfcp_tune.sv ***
// Purpose: Channel to frequency and level to power decode.
// Assumes: Channel and level already range checked.
// Notes:   Pure combinational lookup.
`timescale 1ns/100ps
module rfcp_tune (
  // Settings
  input  wire logic [6:0]         channel_in,
  input  wire logic [2:0]         power_in,
  // Decoded tuning
  output rfcp_pkg::rfcp_tune_t    tune_out
);
  always_comb begin
    if (channel_in >= rfcp_pkg::CHAN_HIGH_BAND) begin
      tune_out.freq_steps = rfcp_pkg::BASE_HIGH_STEPS
        + {9'h000, channel_in - rfcp_pkg::CHAN_HIGH_BAND};
    end else begin
      tune_out.freq_steps = rfcp_pkg::BASE_LOW_STEPS
        + {9'h000, channel_in - rfcp_pkg::CHAN_MIN};
    end
    case (power_in)
      3'h1: tune_out.power_dbm = -8'sd14;
      3'h2: tune_out.power_dbm = -8'sd6;
      3'h3: tune_out.power_dbm = 8'sd0;
      3'h4: tune_out.power_dbm = 8'sd5;
      default: tune_out.power_dbm = 8'sd8;
    endcase
  end
endmodule

// *** rtl/rfcp_ctrl.sv ***
// Purpose: Radio-settings command handler: channel, power, signal strength, amp enables.
// Assumes: Command bytes arrive as one-cycle strobes; reply bytes leave with a ready handshake.
// Notes:   Stored defaults are inputs; run-time registers never write them back.
`timescale 1ns/100ps
module rfcp_ctrl #(
  parameter int PROMPT_CYCLES = rfcp_pkg::PROMPT_CYC,
  parameter int CHAN_CYCLES   = rfcp_pkg::CHAN_CYC
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Mode and stored defaults
  input  wire logic                  config_n_in,
  input  wire rfcp_pkg::rfcp_setting_t stored_in,
  input  wire logic                  tx_active_in,
  input  wire logic [7:0]            rssi_in,
  // Command bytes
  input  wire logic                  cmd_valid_in,
  input  wire logic [7:0]            cmd_data_in,
  // Reply bytes
  output logic                       reply_valid_out,
  output logic [7:0]                 reply_data_out,
  input  wire logic                  reply_ready_in,
  // Radio settings and amp enables
  output rfcp_pkg::rfcp_tune_t       tune_out,
  output logic [6:0]                 channel_out,
  output logic [2:0]                 power_out,
  output logic [7:0]                 air_rate_out,
  output logic                       cont_tx_out,
  output logic                       tx_amp_enable_out,
  output logic                       rx_amp_enable_out
);
  typedef enum {RFCP_IDLE, RFCP_ARG, RFCP_WAIT, RFCP_RSSI, RFCP_PROMPT} rfcp_state_t;
  rfcp_state_t state_q;
  logic [7:0]  pending_q;
  logic [31:0] wait_q;
  logic [7:0]  rssi_q;
  logic        cfg_q;
  logic [6:0]  chan_q;
  logic [2:0]  pow_q;
  logic        cont_q;
  logic        reply_ok;

  assign reply_ok = reply_valid_out && reply_ready_in;

  // Run-time copies live here so commands never touch the stored set.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      chan_q <= rfcp_pkg::CHAN_FACTORY;
      pow_q  <= rfcp_pkg::POWER_FACTORY;
    end else if (cfg_q == 1'b0 && state_q == RFCP_IDLE && pending_q == 8'h00) begin
      chan_q <= stored_in.channel;
      pow_q  <= stored_in.power;
    end else if (state_q == RFCP_ARG && cmd_valid_in) begin
      if (pending_q == rfcp_pkg::CMD_CHAN && cmd_data_in >= {1'b0, rfcp_pkg::CHAN_MIN} &&
          cmd_data_in <= {1'b0, rfcp_pkg::CHAN_MAX}) begin
        chan_q <= cmd_data_in[6:0];
      end
      if (pending_q == rfcp_pkg::CMD_POWER && cmd_data_in >= {5'h00, rfcp_pkg::POWER_MIN} &&
          cmd_data_in <= {5'h00, rfcp_pkg::POWER_MAX}) begin
        pow_q <= cmd_data_in[2:0];
      end
    end
  end

  // Load stored defaults once after reset: pending_q of zero marks "not yet loaded".
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pending_q <= 8'h00;
    end else if (pending_q == 8'h00 && state_q == RFCP_IDLE && !cfg_q) begin
      pending_q <= 8'hFF;
    end else if (state_q == RFCP_IDLE && cfg_q && cmd_valid_in && (|cmd_data_in)) begin
      // A zero command byte would re-arm the marker and wipe the run-time settings.
      pending_q <= cmd_data_in;
    end
  end

  // Command sequencer.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= RFCP_IDLE;
      wait_q  <= 32'h0000_0000;
      cfg_q   <= 1'b0;
      rssi_q  <= 8'h00;
      cont_q  <= 1'b0;
    end else begin
      case (state_q)
        RFCP_IDLE: begin
          if (!config_n_in && !cfg_q) begin
            wait_q <= 32'(PROMPT_CYCLES);
            state_q <= RFCP_WAIT;
          end else if (config_n_in) begin
            cfg_q <= 1'b0;
          end else if (cmd_valid_in) begin
            if (cmd_data_in == rfcp_pkg::CMD_CHAN || cmd_data_in == rfcp_pkg::CMD_POWER) begin
              state_q <= RFCP_ARG;
            end else if (cmd_data_in == rfcp_pkg::CMD_RSSI) begin
              rssi_q <= rssi_in;
              state_q <= RFCP_RSSI;
            end else if (cmd_data_in == rfcp_pkg::CMD_CONT_TX) begin
              cont_q <= 1'b1;
              state_q <= RFCP_PROMPT;
            end else begin
              state_q <= RFCP_PROMPT;
            end
          end
        end
        RFCP_ARG: begin
          if (cmd_valid_in) begin
            if (pending_q == rfcp_pkg::CMD_CHAN) begin
              wait_q <= 32'(CHAN_CYCLES);
              state_q <= RFCP_WAIT;
            end else begin
              state_q <= RFCP_PROMPT;
            end
          end
        end
        RFCP_WAIT: begin
          if (wait_q <= 32'h0000_0001) begin
            cfg_q <= 1'b1;
            state_q <= RFCP_PROMPT;
          end else begin
            wait_q <= wait_q - 32'h0000_0001;
          end
        end
        RFCP_RSSI: begin
          if (reply_ok) begin
            state_q <= RFCP_PROMPT;
          end
        end
        RFCP_PROMPT: begin
          if (reply_ok) begin
            state_q <= RFCP_IDLE;
          end
        end
        default: state_q <= RFCP_IDLE;
      endcase
    end
  end

  always_comb begin
    reply_valid_out = (state_q == RFCP_RSSI) || (state_q == RFCP_PROMPT);
    reply_data_out  = (state_q == RFCP_RSSI) ? rssi_q : rfcp_pkg::PROMPT_CHAR;
  end

  rfcp_tune u_tune (
    .channel_in (chan_q),
    .power_in   (pow_q),
    .tune_out   (tune_out)
  );

  assign channel_out  = chan_q;
  assign power_out    = pow_q;
  assign air_rate_out = stored_in.air_rate;
  assign cont_tx_out  = cont_q;
  // The amps follow the radio mode directly; no extra settling delay is added.
  assign tx_amp_enable_out = tx_active_in || cont_q;
  assign rx_amp_enable_out = !(tx_active_in || cont_q);

  AST_TX_RX_EXCL: assert property (@(posedge clk_in) disable iff (rst_in)
    tx_amp_enable_out != rx_amp_enable_out) else $error("Amp enables overlap.");
  // Steps of the strength query and of an argument byte, shared by the properties below.
  sequence s_rssi_taken;
    state_q == RFCP_IDLE && cfg_q && !config_n_in && cmd_valid_in &&
      cmd_data_in == rfcp_pkg::CMD_RSSI;
  endsequence
  sequence s_byte_sent;
    state_q == RFCP_RSSI && reply_ok;
  endsequence
  sequence s_prompt_shown;
    reply_valid_out && reply_data_out == rfcp_pkg::PROMPT_CHAR;
  endsequence
  sequence s_chan_arg;
    state_q == RFCP_ARG && cmd_valid_in && pending_q == rfcp_pkg::CMD_CHAN;
  endsequence
  sequence s_power_arg;
    state_q == RFCP_ARG && cmd_valid_in && pending_q == rfcp_pkg::CMD_POWER;
  endsequence

  AST_RSSI_THEN_PROMPT: assert property (@(posedge clk_in) disable iff (rst_in)
    s_byte_sent |=> s_prompt_shown)
    else $error("Prompt did not follow strength byte.");
  AST_RSSI_SAMPLE: assert property (@(posedge clk_in) disable iff (rst_in)
    s_rssi_taken |=> reply_valid_out && reply_data_out == $past(rssi_in))
    else $error("Strength not sampled.");
  AST_BAD_CHAN: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == RFCP_ARG && cmd_valid_in && cmd_data_in > {1'b0, rfcp_pkg::CHAN_MAX})
    |=> $stable(chan_q)) else $error("Bad channel accepted.");
  AST_CONT_TX: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == RFCP_IDLE && cfg_q && !config_n_in && cmd_valid_in &&
      cmd_data_in == rfcp_pkg::CMD_CONT_TX) |=> cont_tx_out)
    else $error("Continuous transmit not entered.");
  AST_AIR_RATE: assert property (@(posedge clk_in) disable iff (rst_in)
    air_rate_out == stored_in.air_rate) else $error("Air rate changed at run time.");
  AST_POW_RANGE: assert property (@(posedge clk_in) disable iff (rst_in)
    s_power_arg ##0 (cmd_data_in == 8'h03) |=> power_out == 3'h3)
    else $error("Power level not applied.");
  AST_BAD_POWER: assert property (@(posedge clk_in) disable iff (rst_in)
    s_power_arg ##0 (cmd_data_in < {5'h00, rfcp_pkg::POWER_MIN} ||
      cmd_data_in > {5'h00, rfcp_pkg::POWER_MAX}) |=> $stable(power_out))
    else $error("Bad power level accepted.");
  AST_CHAN_APPLY: assert property (@(posedge clk_in) disable iff (rst_in)
    s_chan_arg ##0 (cmd_data_in >= {1'b0, rfcp_pkg::CHAN_MIN} &&
      cmd_data_in <= {1'b0, rfcp_pkg::CHAN_MAX}) |=> channel_out == $past(cmd_data_in[6:0]))
    else $error("Channel not applied.");
  AST_ARG_NO_REPLY: assert property (@(posedge clk_in) disable iff (rst_in)
    s_chan_arg |=> (!reply_valid_out) [*8])
    else $error("Prompt too early after channel.");
  AST_WAIT_PROMPT: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == RFCP_WAIT && wait_q <= 32'h0000_0001) |=> s_prompt_shown)
    else $error("Prompt missing after wait.");
  // Only the first edge after reset loads the stored set; later entries keep run-time values.
  AST_RESET_LOAD: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |=> channel_out == $past(stored_in.channel) &&
      power_out == $past(stored_in.power))
    else $error("Stored defaults not loaded.");
endmodule

// *** testbench/rfcp_host.sv ***
// Purpose: Host model on the command side of the radio-settings handler.
// Assumes: One command at a time, each reply taken before the next command.
// Notes:   Ready stalls at random, so slow and prompt hosts are both seen.
`timescale 1ns/100ps
module rfcp_host (
  // Clock
  input  wire logic       clk_in,
  // Command side
  output logic            config_n_out,
  output logic            cmd_valid_out,
  output logic [7:0]      cmd_data_out,
  // Reply side
  input  wire logic       reply_valid_in,
  input  wire logic [7:0] reply_data_in,
  output logic            reply_ready_out
);
  int cur_ch = 0;
  initial begin
    config_n_out = 1'b1;
    cmd_valid_out = 1'b0;
    cmd_data_out = 8'h00;
    reply_ready_out = 1'b0;
  end
  task automatic mode(input logic v);
    @(posedge clk_in);
    config_n_out <= v;
  endtask
  task automatic send(input logic [7:0] v);
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_data_out <= v;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
  endtask
  // Channel and level go through the commands only; a cap guards the crowded channels.
  task automatic cmd2(input logic [7:0] op, input logic [7:0] arg);
    logic [7:0] a;
    a = arg;
    if (op == rfcp_pkg::CMD_POWER && cur_ch >= 28 && cur_ch <= 48 && a > 8'h04) a = 8'h04;
    send(op);
    send(a);
    if (op == rfcp_pkg::CMD_CHAN && a >= 8'h01 && a <= 8'h50) cur_ch = a;
  endtask
  // Each reply is awaited before anything further is sent.
  task automatic get(output logic [7:0] b, output int fo, output bit ok);
    b = 8'h00;
    ok = 1'b0;
    fo = -1;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(posedge clk_in);
      if (reply_valid_in && fo < 0) fo = i;
      if (reply_valid_in && reply_ready_out) begin
        b = reply_data_in;
        ok = 1'b1;
      end
      reply_ready_out <= ok ? 1'b0 : 1'($urandom_range(0, 1));
    end
  endtask
endmodule

// *** testbench/rfcp_ctrl_test.sv ***
// Purpose: Self-checking bench for the radio-settings command handler.
// Assumes: Short prompt and channel delays of 4 and 8 cycles.
// Notes:   The model tracks channel and level with integers.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module rfcp_ctrl_test;
  logic                    clk_in = 1'b0;
  logic                    rst_in = 1'b1;
  logic                    tx_active_in = 1'b0;
  logic [7:0]              rssi_in = 8'h00;
  rfcp_pkg::rfcp_setting_t stored_in = '0;
  logic                    config_n, cmd_valid, reply_valid, reply_ready;
  logic                    cont_tx, tx_amp, rx_amp, ok;
  logic [7:0]              cmd_data, reply_data, air_rate, b;
  logic [6:0]              channel;
  logic [2:0]              power;
  rfcp_pkg::rfcp_tune_t    tune;
  int                      n_fail = 0, n_tests = 0, ech, epw, fo, er;
  int                      dbm [1:5] = '{-14, -6, 0, 5, 8};
  initial forever #10 clk_in = ~clk_in;
  rfcp_host host (.clk_in(clk_in), .config_n_out(config_n), .cmd_valid_out(cmd_valid),
    .cmd_data_out(cmd_data), .reply_valid_in(reply_valid), .reply_data_in(reply_data),
    .reply_ready_out(reply_ready));
  rfcp_ctrl #(.PROMPT_CYCLES(4), .CHAN_CYCLES(8)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .config_n_in(config_n), .stored_in(stored_in), .tx_active_in(tx_active_in),
    .rssi_in(rssi_in), .cmd_valid_in(cmd_valid), .cmd_data_in(cmd_data),
    .reply_valid_out(reply_valid), .reply_data_out(reply_data), .reply_ready_in(reply_ready),
    .tune_out(tune), .channel_out(channel), .power_out(power), .air_rate_out(air_rate),
    .cont_tx_out(cont_tx), .tx_amp_enable_out(tx_amp), .rx_amp_enable_out(rx_amp));
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check_state();
    `CHK(channel, 7'(ech))
    `CHK(power, 3'(epw))
    `CHK(tune.freq_steps, 16'(ech < 60 ? 35781 + ech - 1 : 33976 + ech - 60))
    `CHK(tune.power_dbm, 8'(dbm[epw]))
    `CHK(air_rate, stored_in.air_rate)
  endtask
  task automatic prompt(input int lo, input int hi);
    host.get(b, fo, ok);
    if (!ok) begin
      n_fail++;
      end_of_test();
    end else begin
      `CHK(b, rfcp_pkg::PROMPT_CHAR)
      `CHK(fo >= lo && fo <= hi, 1'b1)
    end
  endtask
  task automatic do_reset(input int cyc);
    rst_in <= 1'b1;
    stored_in <= '{7'($urandom_range(1, 80)), 3'($urandom_range(1, 5)), 8'($urandom)};
    repeat (cyc) @(posedge clk_in);
    `CHK(channel, rfcp_pkg::CHAN_FACTORY)
    `CHK(power, rfcp_pkg::POWER_FACTORY)
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    ech = stored_in.channel;
    epw = stored_in.power;
    check_state();
  endtask
  initial begin
    void'($urandom(32'h4C58BCD4));
    do_reset(16);
    host.mode(1'b0);
    prompt(3, 6);
    host.cmd2(rfcp_pkg::CMD_CHAN, 8'h0A);
    ech = 10;
    prompt(6, 9);
    for (int p = 0; p <= 6; p++) begin
      host.cmd2(rfcp_pkg::CMD_POWER, 8'(p));
      if (p >= 1 && p <= 5) epw = p;
      prompt(0, 1);
      check_state();
    end
    host.cmd2(rfcp_pkg::CMD_POWER, 8'h03);
    epw = 3;
    prompt(0, 1);
    for (int c = 0; c <= 81; c++) begin
      host.cmd2(rfcp_pkg::CMD_CHAN, 8'(c));
      if (c >= 1 && c <= 80) ech = c;
      prompt(6, 9);
      check_state();
    end
    host.cmd2(rfcp_pkg::CMD_CHAN, 8'h1E);
    ech = 30;
    prompt(6, 9);
    host.cmd2(rfcp_pkg::CMD_POWER, 8'h05);
    epw = 4;
    prompt(0, 1);
    check_state();
    host.send(8'h54);
    prompt(0, 1);
    check_state();
    for (int k = 0; k < 3; k++) begin
      rssi_in <= 8'($urandom);
      host.send(rfcp_pkg::CMD_RSSI);
      // The level moves right after the query is taken; the byte must keep the old one.
      er = rssi_in;
      rssi_in <= ~rssi_in;
      host.get(b, fo, ok);
      if (!ok) begin
        n_fail++;
        end_of_test();
      end else begin
        `CHK(b, 8'(er))
        `CHK(fo, 0)
      end
      prompt(0, 1);
    end
    for (int k = 1; k <= 4; k++) begin
      tx_active_in <= k[0];
      @(posedge clk_in);
      `CHK(tx_amp, k[0])
      `CHK(rx_amp, ~k[0])
    end
    host.send(rfcp_pkg::CMD_CONT_TX);
    prompt(0, 1);
    `CHK(cont_tx, 1'b1)
    `CHK(tx_amp, 1'b1)
    `CHK(rx_amp, 1'b0)
    host.mode(1'b1);
    repeat (2) @(posedge clk_in);
    host.mode(1'b0);
    prompt(3, 6);
    check_state();
    host.mode(1'b1);
    do_reset(3);
    end_of_test();
  end
endmodule
